/* src/ipfb_pkg.sv */
/*
  Shared constants and carrier types for the interrupt priority field bank.
  Assumes a single clock domain and a plain register port with 16-bit data.
*/
package ipfb_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_REGS = 6;
  localparam int NUM_SRC = 17;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 3;

  // ---------------------------------------------------------------
  // register indices on the register port
  // ---------------------------------------------------------------
  localparam logic [2:0] IDX_CRC_UART_ERR = 3'h0;
  localparam logic [2:0] IDX_LOW_VOLTAGE = 3'h1;
  localparam logic [2:0] IDX_CHARGE_TIME = 3'h2;
  localparam logic [2:0] IDX_THIRD_UART = 3'h3;
  localparam logic [2:0] IDX_USB_I2C_UART = 3'h4;
  localparam logic [2:0] IDX_SPI_UART4 = 3'h5;

  // ---------------------------------------------------------------
  // field positions (lsb of each 3-bit field)
  // ---------------------------------------------------------------
  localparam int LSB_HI = 12;
  localparam int LSB_MH = 8;
  localparam int LSB_ML = 4;
  localparam int LSB_LO = 0;

  // ---------------------------------------------------------------
  // priority codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_MIN = 3'h1;
  localparam logic [2:0] PRIO_MAX = 3'h7;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  // every field resets to 100, unimplemented bits are masked off
  localparam logic [15:0] RESET_PATTERN = 16'h4444;
  localparam logic [15:0] REG_MASK [NUM_REGS] = '{
    16'h7770, 16'h0007, 16'h0070, 16'h7770, 16'h7777, 16'h7777};
  localparam logic [15:0] RD_UNMAPPED = 16'h0000;

  // ---------------------------------------------------------------
  // source positions in the request vectors
  // ---------------------------------------------------------------
  localparam int SRC_CRC = 0;
  localparam int SRC_SER2_ERR = 1;
  localparam int SRC_SER1_ERR = 2;
  localparam int SRC_LOW_VOLT = 3;
  localparam int SRC_CHARGE = 4;
  localparam int SRC_SER3_TX = 5;
  localparam int SRC_SER3_RX = 6;
  localparam int SRC_SER3_ERR = 7;
  localparam int SRC_SER4_ERR = 8;
  localparam int SRC_USB = 9;
  localparam int SRC_TW3_MST = 10;
  localparam int SRC_TW3_SLV = 11;
  localparam int SRC_SYNC3_EVT = 12;
  localparam int SRC_SYNC3_FLT = 13;
  localparam int SRC_SER4_TX = 14;
  localparam int SRC_SER4_RX = 15;
  localparam int SRC_SPARE = 16;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
  } ipfb_bus_req_t;

  typedef struct packed {
    logic [2:0] crc_error_priority;
    logic [2:0] serial2_error_priority;
    logic [2:0] serial1_error_priority;
    logic [2:0] low_voltage_priority;
    logic [2:0] charge_time_priority;
    logic [2:0] serial3_transmit_priority;
    logic [2:0] serial3_receive_priority;
    logic [2:0] serial3_error_priority;
    logic [2:0] serial4_error_priority;
    logic [2:0] usb_event_priority;
    logic [2:0] twowire3_master_priority;
    logic [2:0] twowire3_slave_priority;
    logic [2:0] sync3_event_priority;
    logic [2:0] sync3_fault_priority;
    logic [2:0] serial4_transmit_priority;
    logic [2:0] serial4_receive_priority;
  } ipfb_prio_t;

  typedef logic [NUM_SRC-1:0] ipfb_src_vec_t;

endpackage

/* src/ipfb_priority_bank.sv */
/*
  Bank of six priority registers that set the level of each peripheral
  interrupt source and gate requests of disabled sources.
  Assumes one clock, an asynchronous active-low reset and a register port
  whose master never asserts read and write strobes together.
*/
// Notes on behaviour
// RULE1: three-bit fields, code 111 is level 7
// RULE2: code 001 is level 1, linear between
// RULE3: code 000 blocks the source's request entirely
// RULE4: unused bits read zero, ignore writes
// RULE5: every field resets to 100, read/write
// RULE6: reg0: crc 14-12, serial2 10-8, serial1 6-4
// RULE7: reg1: low voltage 2-0, rest unused
// RULE8: reg2: charge time 6-4, rest unused
// RULE9: reg3: serial3 tx 14-12, rx 10-8, err 6-4
// RULE10: reg4: serial4 err, usb, twowire3 master, slave
// RULE11: reg5: sync3 event, fault, serial4 tx, rx
// RULE12: fields drive arbitration from next cycle
`timescale 1ns/1ns
module ipfb_priority_bank
  import ipfb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire ipfb_pkg::ipfb_bus_req_t busReq,
  output logic [15:0] rdData,
  // toward the arbitration logic
  input wire ipfb_pkg::ipfb_src_vec_t srcReq,
  output ipfb_pkg::ipfb_src_vec_t srcReqGated,
  output ipfb_pkg::ipfb_prio_t prio
);

  import ipfb_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // address decode, shared by write enables and read mux
  function automatic logic regHit(input logic [2:0] addr, input int idx);
    regHit = (addr == idx[2:0]);
  endfunction

  // pick one 3-bit field out of a register
  function automatic logic [2:0] fieldOf(input logic [15:0] r, input int lsb);
    fieldOf = r[lsb +: FIELD_W];
  endfunction

  // code to level: linear, 000 means no level at all
  function automatic logic [2:0] levelOf(input logic [2:0] code);
    levelOf = code;
  endfunction

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [15:0] regVal [NUM_REGS];
  logic [NUM_REGS-1:0] wrEn;

  // one slot per register; mask keeps unused bits at zero
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_slot
    assign wrEn[i] = busReq.wr && regHit(busReq.addr, i);
    ipfb_reg_slot #(
      .MASK(REG_MASK[i]),
      .RST(REG_MASK[i] & RESET_PATTERN) // [RULE5]
    ) u_slot (
      .clk(clk),
      .arst_n(arst_n),
      .wrEn(wrEn[i]), // [RULE12]
      .wrData(busReq.wdata), // [RULE4]
      .value(regVal[i])
    );
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [15:0] rdMux;
  logic [15:0] rdData_ff;

  // unmapped indices answer zero rather than stale data
  always_comb begin
    rdMux = RD_UNMAPPED;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (regHit(busReq.addr, i)) begin
        rdMux = regVal[i]; // [RULE4]
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_ff <= RD_UNMAPPED;
    end else if (busReq.rd) begin
      rdData_ff <= rdMux;
    end else begin
      rdData_ff <= RD_UNMAPPED;
    end
  end

  assign rdData = rdData_ff;

  // ---------------------------------------------------------------
  // field map
  // ---------------------------------------------------------------

  // straight from the register flops, no extra stage
  always_comb begin
    prio.crc_error_priority = fieldOf(regVal[0], LSB_HI); // [RULE6]
    prio.serial2_error_priority = fieldOf(regVal[0], LSB_MH); // [RULE6]
    prio.serial1_error_priority = fieldOf(regVal[0], LSB_ML); // [RULE6]
    prio.low_voltage_priority = fieldOf(regVal[1], LSB_LO); // [RULE7]
    prio.charge_time_priority = fieldOf(regVal[2], LSB_ML); // [RULE8]
    prio.serial3_transmit_priority = fieldOf(regVal[3], LSB_HI); // [RULE9]
    prio.serial3_receive_priority = fieldOf(regVal[3], LSB_MH); // [RULE9]
    prio.serial3_error_priority = fieldOf(regVal[3], LSB_ML); // [RULE9]
    prio.serial4_error_priority = fieldOf(regVal[4], LSB_HI); // [RULE10]
    prio.usb_event_priority = fieldOf(regVal[4], LSB_MH); // [RULE10]
    prio.twowire3_master_priority = fieldOf(regVal[4], LSB_ML); // [RULE10]
    prio.twowire3_slave_priority = fieldOf(regVal[4], LSB_LO); // [RULE10]
    prio.sync3_event_priority = fieldOf(regVal[5], LSB_HI); // [RULE11]
    prio.sync3_fault_priority = fieldOf(regVal[5], LSB_MH); // [RULE11]
    prio.serial4_transmit_priority = fieldOf(regVal[5], LSB_ML); // [RULE11]
    prio.serial4_receive_priority = fieldOf(regVal[5], LSB_LO); // [RULE11]
  end

  // ---------------------------------------------------------------
  // request gating
  // ---------------------------------------------------------------
  logic [2:0] srcLevel [NUM_SRC];

  // levels in source order; the spare slot has no field and stays off
  always_comb begin
    srcLevel[SRC_CRC] = levelOf(prio.crc_error_priority); // [RULE1] [RULE2]
    srcLevel[SRC_SER2_ERR] = levelOf(prio.serial2_error_priority);
    srcLevel[SRC_SER1_ERR] = levelOf(prio.serial1_error_priority);
    srcLevel[SRC_LOW_VOLT] = levelOf(prio.low_voltage_priority);
    srcLevel[SRC_CHARGE] = levelOf(prio.charge_time_priority);
    srcLevel[SRC_SER3_TX] = levelOf(prio.serial3_transmit_priority);
    srcLevel[SRC_SER3_RX] = levelOf(prio.serial3_receive_priority);
    srcLevel[SRC_SER3_ERR] = levelOf(prio.serial3_error_priority);
    srcLevel[SRC_SER4_ERR] = levelOf(prio.serial4_error_priority);
    srcLevel[SRC_USB] = levelOf(prio.usb_event_priority);
    srcLevel[SRC_TW3_MST] = levelOf(prio.twowire3_master_priority);
    srcLevel[SRC_TW3_SLV] = levelOf(prio.twowire3_slave_priority);
    srcLevel[SRC_SYNC3_EVT] = levelOf(prio.sync3_event_priority);
    srcLevel[SRC_SYNC3_FLT] = levelOf(prio.sync3_fault_priority);
    srcLevel[SRC_SER4_TX] = levelOf(prio.serial4_transmit_priority);
    srcLevel[SRC_SER4_RX] = levelOf(prio.serial4_receive_priority);
    srcLevel[SRC_SPARE] = PRIO_OFF;
  end

  // a disabled source never reaches the arbiter, whatever its flag
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_gate
    assign srcReqGated[s] = srcReq[s] && (srcLevel[s] != PRIO_OFF); // [RULE3]
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic wroteAny_ff;

  // helper: no field has been written since reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wroteAny_ff <= 1'b0;
    end else if (|wrEn) begin
      wroteAny_ff <= 1'b1;
    end
  end

  a_reset_fields: assert property ( // [RULE5]
    @(posedge clk) disable iff (!arst_n)
    !wroteAny_ff |-> (prio.crc_error_priority == PRIO_RESET
      && prio.low_voltage_priority == PRIO_RESET
      && prio.serial4_receive_priority == PRIO_RESET))
    else $error("field not at reset code before first write");

  a_unused_lowvolt: assert property ( // [RULE7]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_LOW_VOLTAGE
    |=> regVal[1][15:3] == 13'h0000
      && prio.low_voltage_priority == $past(busReq.wdata[2:0]))
    else $error("low voltage register map wrong");

  a_unused_charge: assert property ( // [RULE8]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_CHARGE_TIME
    |=> regVal[2] == ($past(busReq.wdata) & 16'h0070))
    else $error("charge time register map wrong");

  a_crc_fields: assert property ( // [RULE6]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_CRC_UART_ERR
    |=> prio.crc_error_priority == $past(busReq.wdata[14:12])
      && prio.serial1_error_priority == $past(busReq.wdata[6:4]))
    else $error("crc register field position wrong");

  a_uart3_fields: assert property ( // [RULE9]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_THIRD_UART
    |=> prio.serial3_receive_priority == $past(busReq.wdata[10:8])
      && regVal[3][3:0] == 4'h0)
    else $error("third serial register map wrong");

  a_usb_fields: assert property ( // [RULE10]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_USB_I2C_UART
    |=> prio.usb_event_priority == $past(busReq.wdata[10:8])
      && prio.twowire3_slave_priority == $past(busReq.wdata[2:0]))
    else $error("usb register field position wrong");

  a_sync3_fields: assert property ( // [RULE11]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_SPI_UART4
    |=> prio.sync3_fault_priority == $past(busReq.wdata[10:8])
      && prio.serial4_transmit_priority == $past(busReq.wdata[6:4]))
    else $error("sync3 register field position wrong");

  a_unused_readzero: assert property ( // [RULE4]
    @(posedge clk) disable iff (!arst_n)
    busReq.rd && busReq.addr == IDX_CRC_UART_ERR
    |=> (rdData & 16'h888F) == 16'h0000 && rdData == $past(regVal[0]))
    else $error("unimplemented bits read nonzero");

  a_unmapped_read: assert property ( // [RULE4]
    @(posedge clk) disable iff (!arst_n)
    busReq.rd && busReq.addr > IDX_SPI_UART4 |=> rdData == 16'h0000)
    else $error("unmapped read not zero");

  a_disabled_gate: assert property ( // [RULE3]
    @(posedge clk) disable iff (!arst_n)
    prio.usb_event_priority == PRIO_OFF |-> !srcReqGated[SRC_USB])
    else $error("disabled source passed a request");

  a_enabled_pass: assert property ( // [RULE1] [RULE2]
    @(posedge clk) disable iff (!arst_n)
    srcReq[SRC_CRC] && prio.crc_error_priority >= PRIO_MIN
      && prio.crc_error_priority <= PRIO_MAX
    |-> srcReqGated[SRC_CRC])
    else $error("enabled source request dropped");

  a_write_hold: assert property ( // [RULE12]
    @(posedge clk) disable iff (!arst_n)
    !(busReq.wr && busReq.addr == IDX_SPI_UART4)
    |=> $stable(prio.sync3_event_priority))
    else $error("field changed without a write");

  a_write_effect: assert property ( // [RULE12]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_SPI_UART4 && busReq.wdata[14:12] == PRIO_OFF
      && srcReq[SRC_SYNC3_EVT]
    |=> !(srcReq[SRC_SYNC3_EVT] && srcReqGated[SRC_SYNC3_EVT]))
    else $error("written priority late to take effect");

  // every field, not only the sampled three, sits at 100 until written
  a_reset_all: assert property ( // [RULE5]
    @(posedge clk) disable iff (!arst_n)
    !wroteAny_ff |-> prio == {(NUM_SRC - 1){PRIO_RESET}})
    else $error("bank not at reset codes before first write");

  a_serial2_field: assert property ( // [RULE6]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_CRC_UART_ERR
    |=> prio.serial2_error_priority == $past(busReq.wdata[10:8])
      && (regVal[0] & 16'h888F) == 16'h0000)
    else $error("serial2 error field position wrong");

  a_uart3_outer: assert property ( // [RULE9]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_THIRD_UART
    |=> prio.serial3_transmit_priority == $past(busReq.wdata[14:12])
      && prio.serial3_error_priority == $past(busReq.wdata[6:4]))
    else $error("third serial outer fields wrong");

  a_usb_outer: assert property ( // [RULE10]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_USB_I2C_UART
    |=> prio.serial4_error_priority == $past(busReq.wdata[14:12])
      && prio.twowire3_master_priority == $past(busReq.wdata[6:4]))
    else $error("serial4 error or twowire3 master field wrong");

  a_sync3_outer: assert property ( // [RULE11]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr == IDX_SPI_UART4
    |=> prio.sync3_event_priority == $past(busReq.wdata[14:12])
      && prio.serial4_receive_priority == $past(busReq.wdata[2:0]))
    else $error("sync3 event or serial4 receive field wrong");

  // a write to an unmapped index must leave every field alone
  a_unmapped_write: assert property ( // [RULE4]
    @(posedge clk) disable iff (!arst_n)
    busReq.wr && busReq.addr > IDX_SPI_UART4 |=> $stable(prio))
    else $error("unmapped write changed a field");

  // read data are a one-cycle pulse; idle cycles answer zero
  a_read_idle: assert property ( // [RULE4]
    @(posedge clk) disable iff (!arst_n)
    !busReq.rd |=> rdData == 16'h0000)
    else $error("read data outside a read cycle");

  // read value rebuilt from the fields, so a crossed read mux shows up
  a_read_crc: assert property ( // [RULE6]
    @(posedge clk) disable iff (!arst_n)
    busReq.rd && busReq.addr == IDX_CRC_UART_ERR
    |=> rdData == {1'b0, $past(prio.crc_error_priority), 1'b0, $past(prio.serial2_error_priority),
      1'b0, $past(prio.serial1_error_priority), 4'h0})
    else $error("crc register read value wrong");

  a_read_lowvolt: assert property ( // [RULE7]
    @(posedge clk) disable iff (!arst_n)
    busReq.rd && busReq.addr == IDX_LOW_VOLTAGE
    |=> rdData == {13'h0, $past(prio.low_voltage_priority)})
    else $error("low voltage register read value wrong");

  a_read_charge: assert property ( // [RULE8]
    @(posedge clk) disable iff (!arst_n)
    busReq.rd && busReq.addr == IDX_CHARGE_TIME
    |=> rdData == {9'h0, $past(prio.charge_time_priority), 4'h0})
    else $error("charge time register read value wrong");

  a_read_uart3: assert property ( // [RULE9]
    @(posedge clk) disable iff (!arst_n)
    busReq.rd && busReq.addr == IDX_THIRD_UART
    |=> rdData == {1'b0, $past(prio.serial3_transmit_priority), 1'b0, $past(prio.serial3_receive_priority),
      1'b0, $past(prio.serial3_error_priority), 4'h0})
    else $error("third serial register read value wrong");

  a_read_usb: assert property ( // [RULE10]
    @(posedge clk) disable iff (!arst_n)
    busReq.rd && busReq.addr == IDX_USB_I2C_UART
    |=> rdData == {1'b0, $past(prio.serial4_error_priority), 1'b0, $past(prio.usb_event_priority),
      1'b0, $past(prio.twowire3_master_priority), 1'b0, $past(prio.twowire3_slave_priority)})
    else $error("usb register read value wrong");

  a_read_sync3: assert property ( // [RULE11]
    @(posedge clk) disable iff (!arst_n)
    busReq.rd && busReq.addr == IDX_SPI_UART4
    |=> rdData == {1'b0, $past(prio.sync3_event_priority), 1'b0, $past(prio.sync3_fault_priority),
      1'b0, $past(prio.serial4_transmit_priority), 1'b0, $past(prio.serial4_receive_priority)})
    else $error("sync3 register read value wrong");

  // the spare slot has no field, so it must never raise a request
  a_spare_off: assert property ( // [RULE3]
    @(posedge clk) disable iff (!arst_n)
    !srcReqGated[SRC_SPARE])
    else $error("spare source passed a request");

  // each real source, read straight off the field carrier: passes only when not 000
  for (genvar s = 0; s < NUM_SRC - 1; s++) begin : g_gate_chk
    a_gate_each: assert property ( // [RULE1] [RULE2] [RULE3]
      @(posedge clk) disable iff (!arst_n)
      srcReqGated[s] == (srcReq[s] && prio[(NUM_SRC - 2 - s) * FIELD_W +: FIELD_W] != PRIO_OFF))
      else $error("request gating differs from field code");
  end

endmodule

/* src/ipfb_reg_slot.sv */
/*
  One 16-bit priority register with a fixed mask of implemented bits.
  Assumes the caller decodes the address and gives a one-cycle write enable.
*/
`timescale 1ns/1ns
module ipfb_reg_slot #(
  parameter logic [15:0] MASK = 16'h0000,
  parameter logic [15:0] RST = 16'h0000
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write side
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  // stored value
  output logic [15:0] value
);

  logic [15:0] value_ff;

  // masked store: unimplemented bits never leave zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value_ff <= RST & MASK;
    end else if (wrEn) begin
      value_ff <= wrData & MASK;
    end
  end

  assign value = value_ff;

endmodule

/* tb/interrupt_priority_field_bank_test.sv */
/*
  Self-checking bench for the priority field bank: reset values, field
  placement, unused bits, unmapped places and request gating, random stimulus.
  Assumes the package and the arbitration model are compiled before it.
*/
`timescale 1ns/1ns
module interrupt_priority_field_bank_test;
  import ipfb_pkg::*;
  // ---------------------------------------------------------------
  // signals and expectation tables
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  ipfb_bus_req_t busReq = '0;
  ipfb_src_vec_t srcReq = '0;
  logic [15:0] rdData;
  ipfb_src_vec_t srcReqGated;
  ipfb_prio_t prio;
  logic [2:0] topLevel;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [15:0] sh [6];
  // implemented bits of each register
  localparam logic [15:0] IMPL [6] = '{16'h7770, 16'h0007, 16'h0070, 16'h7770, 16'h7777, 16'h7777};
  // register and lsb of each source's field, in source order
  localparam int FREG [16] = '{0, 0, 0, 1, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5, 5, 5};
  localparam int FLSB [16] = '{12, 8, 4, 0, 4, 12, 8, 4, 12, 8, 4, 0, 12, 8, 4, 0};

  // free-running clock, 8 ns
  initial begin
    forever #4 clk = ~clk;
  end

  ipfb_priority_bank dut_u (.clk(clk), .arst_n(arst_n), .busReq(busReq), .rdData(rdData),
    .srcReq(srcReq), .srcReqGated(srcReqGated), .prio(prio));
  ipfb_arb_model arb_u (.srcReqGated(srcReqGated), .prio(prio), .topLevel(topLevel));

  // ---------------------------------------------------------------
  // expectations from the shadow copy
  // ---------------------------------------------------------------
  function automatic logic [2:0] code_of(int i);
    return sh[FREG[i]][FLSB[i] +: 3];
  endfunction

  function automatic logic [47:0] exp_prio();
    logic [47:0] p;
    for (int i = 0; i < 16; i++) p[(15-i)*3 +: 3] = code_of(i);
    return p;
  endfunction

  // the spare bit never passes; a 000 field blocks its source
  function automatic logic [16:0] exp_gate(logic [16:0] req);
    logic [16:0] g;
    g = '0;
    for (int i = 0; i < 16; i++) g[i] = req[i] && (code_of(i) != 3'h0);
    return g;
  endfunction

  function automatic logic [2:0] exp_top(logic [16:0] req);
    logic [2:0] t;
    t = 3'h0;
    for (int i = 0; i < 16; i++) if (req[i] && code_of(i) > t) t = code_of(i);
    return t;
  endfunction

  // ---------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------
  task automatic check(logic [47:0] got, logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_state();
    check(48'(prio), exp_prio());
    check(48'(srcReqGated), 48'(exp_gate(srcReq)));
    check(48'(topLevel), 48'(exp_top(srcReq)));
  endtask

  // one strobe cycle, then an idle cycle in which read data stand
  task automatic access(logic wr, logic [2:0] a, logic [15:0] d);
    logic [15:0] rexp;
    rexp = 16'h0;
    if (!wr && a < 3'h6) rexp = sh[a];
    @(posedge clk);
    busReq <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk);
    busReq <= '0;
    srcReq <= 17'($urandom);
    if (wr && a < 3'h6) sh[a] = d & IMPL[a];
    #1;
    check(48'(rdData), 48'(rexp));
    check_state();
  endtask

  // reset needs no clock; it is held across two edges
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int r = 0; r < 6; r++) sh[r] = 16'h4444 & IMPL[r];
    #1;
    check_state();
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h2d50));
    do_reset();
    // reset values, then the two unmapped places
    for (int a = 0; a < 8; a++) access(1'b0, 3'(a), 16'h0);
    // every code in every field, bits 15, 11, 7 and 3 written high each time
    for (int c = 0; c < 8; c++) begin
      for (int a = 0; a < 6; a++) access(1'b1, 3'(a), {4{1'b1, 3'(c)}});
      for (int a = 0; a < 6; a++) access(1'b0, 3'(a), 16'h0);
    end
    // random mix, unmapped writes included, must not disturb the bank
    for (int n = 0; n < 60; n++) access(1'($urandom), 3'($urandom), 16'($urandom));
    // reset in mid-run brings every field back to 100
    do_reset();
    for (int a = 0; a < 6; a++) access(1'b0, 3'(a), 16'h0);
    test_done();
  end

  // cut a hang short well beyond the few hundred cycles the run needs
  initial begin
    #(8 * 5000);
    n_mismatch++;
    test_done();
  end
endmodule

/* tb/ipfb_arb_model.sv */
/*
  Behavioural model of the interrupt arbitration logic that consumes the bank.
  Assumes the bank's gated requests and priority fields settle within a cycle.
*/
`timescale 1ns/1ns
module ipfb_arb_model
  import ipfb_pkg::*;
(
  // from the bank
  input wire ipfb_pkg::ipfb_src_vec_t srcReqGated,
  input wire ipfb_pkg::ipfb_prio_t prio,
  // winning level toward the processor
  output logic [2:0] topLevel
);
  // ---------------------------------------------------------------
  // level pick
  // ---------------------------------------------------------------
  // the code is the level unchanged, so 111 beats all and 001 loses to all
  // no gating of its own, but a 000 field never beats the starting level 0, so a disabled source that leaks through does not show up here
  always_comb begin
    logic [47:0] flat;
    flat = prio;
    topLevel = 3'h0;
    for (int i = 0; i < 16; i++) begin
      if (srcReqGated[i] && flat[(15-i)*3 +: 3] > topLevel) begin  // fields read live
        topLevel = flat[(15-i)*3 +: 3];
      end
    end
  end
endmodule
